//--- common/fifo_ctrl_pkg.sv
// Behaviour
// - master reset zeroes write and read counters
// - master reset clears latches, sets empty flags
// - gated push follows push only when not full
// - gated push drives left select and enable
// - gated pop follows pop only when not empty
// - gated pop drives right enables; right reads
// - empty clears after first word written
// - almost empty while two or fewer words
// - almost full once six words held
// - almost full clears below six words
// - full at eight words, pushes refused
// - one pop from full reopens pushes
// - empty sets when all words popped
// - flags change only while both strobes high, or on master reset
// - write counter steps per accepted push
// - read counter steps per accepted pop
// - all strobes are active low
// - counters step on strobe falling edge
// - address latch updates on strobe rising edge
// - fill is write minus read, compared
// - four-bit addresses, eight-bit data paths
// - full clears below eight when idle
package fifo_ctrl_pkg;

  localparam int DATA_W      = 8;   // ram data path width
  localparam int ADDR_W      = 4;   // ram address width
  localparam int STAGE_DEPTH = 16;  // words in the read staging buffer

  // fill thresholds, comparable with the four-bit fill count
  localparam logic [3:0] FULL_LEVEL   = 4'h8;
  localparam logic [3:0] AFULL_LEVEL  = 4'h6;
  localparam logic [3:0] AEMPTY_LEVEL = 4'h2;
  localparam logic [3:0] EMPTY_LEVEL  = 4'h0;

  // values after reset
  localparam logic [3:0] ADDR_RESET = 4'h0;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // hold count a gated strobe must reach before it may rise, so it stays low at least four cycles, covers the data sampler
  localparam logic [1:0] STROBE_MIN_CYC = 2'h3;

  // one side of the controller: waiting or inside a strobe
  typedef enum logic [1:0] {
    SIDE_IDLE   = 2'b01,
    SIDE_ACTIVE = 2'b10
  } side_state_t;

endpackage : fifo_ctrl_pkg

//--- core/stage_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module stage_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  // storage, pointers and registered handshake outputs in one record
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wp;
    logic [PW-1:0]               rp;
    logic [CW-1:0]               cnt;
    logic                        in_ready;
    logic                        out_valid;
    logic [WIDTH-1:0]            head;
  } fifo_state_t;

  fifo_state_t r, n;
  logic        do_push;
  logic        do_pop;

  // next state; the head word is prefetched so out_data is a flop
  always_comb begin
    n       = r;
    do_push = in_valid && r.in_ready;
    do_pop  = r.out_valid && out_ready;
    if (do_push) begin
      n.mem[r.wp] = in_data;
      n.wp = (r.wp == PW'(DEPTH - 1)) ? '0 : PW'(r.wp + 1'b1);
    end
    if (do_pop) begin
      n.rp = (r.rp == PW'(DEPTH - 1)) ? '0 : PW'(r.rp + 1'b1);
    end
    if (do_push && !do_pop) begin
      n.cnt = CW'(r.cnt + 1'b1);
    end else if (do_pop && !do_push) begin
      n.cnt = CW'(r.cnt - 1'b1);
    end
    n.in_ready  = (n.cnt != CW'(DEPTH));
    n.out_valid = (n.cnt != '0);
    n.head      = n.mem[n.rp];
  end

  // register the record; empty after reset
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      r          <= '0;
      r.in_ready <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign in_ready  = r.in_ready;
  assign out_valid = r.out_valid;
  assign out_data  = r.head;

endmodule : stage_fifo
`default_nettype wire

//--- core/ram_fifo_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
module ram_fifo_ctrl #(
  parameter int         DATA_W       = fifo_ctrl_pkg::DATA_W,
  parameter int         ADDR_W       = fifo_ctrl_pkg::ADDR_W,
  parameter int         STAGE_DEPTH  = fifo_ctrl_pkg::STAGE_DEPTH,
  parameter logic [3:0] FULL_LEVEL   = fifo_ctrl_pkg::FULL_LEVEL,
  parameter logic [3:0] AFULL_LEVEL  = fifo_ctrl_pkg::AFULL_LEVEL,
  parameter logic [3:0] AEMPTY_LEVEL = fifo_ctrl_pkg::AEMPTY_LEVEL
) (
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  input  wire logic              master_reset_n,
  input  wire logic              push_n,
  input  wire logic              pop_n,
  input  wire logic [DATA_W-1:0] push_data,
  output logic      [ADDR_W-1:0] write_address_bus,
  output logic      [ADDR_W-1:0] read_address_bus,
  output logic      [DATA_W-1:0] write_data_bus,
  input  wire logic [DATA_W-1:0] read_data_bus,
  output logic                   gated_push_n,
  output logic                   gated_pop_n,
  output logic                   left_port_write_select,
  output logic                   left_port_chip_enable_n,
  output logic                   left_port_output_enable_n,
  output logic                   right_port_output_enable_n,
  output logic                   right_port_chip_enable_n,
  output logic                   right_port_write_select,
  output logic                   full,
  output logic                   almost_full,
  output logic                   almost_empty,
  output logic                   empty,
  output logic                   out_valid,
  input  wire logic              out_ready,
  output logic      [DATA_W-1:0] out_data
);

  // whole controller state in one record
  typedef struct packed {
    fifo_ctrl_pkg::side_state_t push_st;  // write side sequencer
    fifo_ctrl_pkg::side_state_t pop_st;   // read side sequencer
    logic [ADDR_W-1:0] wr_cnt;    // write counter
    logic [ADDR_W-1:0] rd_cnt;    // read counter
    logic [ADDR_W-1:0] wr_addr;   // latched write address
    logic [ADDR_W-1:0] rd_addr;   // latched read address
    logic [1:0]        wr_hold;   // cycles spent in a push strobe
    logic [1:0]        rd_hold;   // cycles spent in a pop strobe
    logic              wr_fresh;  // flags seen since last push
    logic              rd_fresh;  // flags seen since last pop
    logic              full;
    logic              afull;
    logic              aempty;
    logic              empty;
    logic              gpush_n;   // gated push strobe
    logic              gpop_n;    // gated pop strobe
    logic              oel_n;     // left output enable, always off
    logic              rws;       // right write select, always read
    logic [DATA_W-1:0] wdata;     // data held toward the left port
    logic              push_s1;
    logic              push_s2;
    logic              pop_s1;
    logic              pop_s2;
    logic              mr_s1;
    logic              mr_s2;
    logic [DATA_W-1:0] din_s1;
    logic [DATA_W-1:0] din_s2;
    logic [DATA_W-1:0] rdat_s1;
    logic [DATA_W-1:0] rdat_s2;
    logic              stage_valid;  // one-cycle write into staging
    logic [DATA_W-1:0] stage_data;
  } ctrl_state_t;

  ctrl_state_t st_r;        // registered state
  ctrl_state_t st_nxt;      // next state
  logic              quiet_w;      // both strobes idle and released
  logic              mr_act_w;     // synchronised master reset active
  logic [ADDR_W-1:0] fill_w;       // words held in the ram
  logic              stage_ready;  // staging buffer has room

  // master reset is a pin, seen only after its second flop
  assign mr_act_w = !st_r.mr_s2;

  // flags may only move when nothing is in flight, or on master reset
  assign quiet_w = st_r.push_s2 && st_r.pop_s2
                && (st_r.push_st == fifo_ctrl_pkg::SIDE_IDLE)
                && (st_r.pop_st == fifo_ctrl_pkg::SIDE_IDLE);

  // unsigned difference wraps with the counters
  assign fill_w = ADDR_W'(st_r.wr_cnt - st_r.rd_cnt);

  // next state of the whole controller
  always_comb begin
    st_nxt = st_r;
    // pins pass two flops before any logic reads them
    st_nxt.push_s1 = push_n;
    st_nxt.push_s2 = st_r.push_s1;
    st_nxt.pop_s1  = pop_n;
    st_nxt.pop_s2  = st_r.pop_s1;
    st_nxt.mr_s1   = master_reset_n;
    st_nxt.mr_s2   = st_r.mr_s1;
    st_nxt.din_s1  = push_data;
    st_nxt.din_s2  = st_r.din_s1;
    st_nxt.rdat_s1 = read_data_bus;
    st_nxt.rdat_s2 = st_r.rdat_s1;
    // fixed port controls
    st_nxt.oel_n       = 1'b1;
    st_nxt.rws         = 1'b1;
    st_nxt.stage_valid = 1'b0;
    // write side sequencer
    case (st_r.push_st)
      fifo_ctrl_pkg::SIDE_IDLE: begin
        // low strobe is a request; refused while full
        if (!st_r.push_s2 && !st_r.full && st_r.wr_fresh) begin
          st_nxt.push_st  = fifo_ctrl_pkg::SIDE_ACTIVE;
          st_nxt.gpush_n  = 1'b0;
          // counter steps as the gated strobe falls
          st_nxt.wr_cnt   = ADDR_W'(st_r.wr_cnt + 1'b1);
          st_nxt.wr_hold  = 2'h0;
          st_nxt.wr_fresh = 1'b0;
          // word passed the same two flops as the strobe, so take it now
          st_nxt.wdata    = st_r.din_s2;
        end else begin
          // data tracks the source until a write begins
          st_nxt.wdata = st_r.din_s2;
        end
      end
      fifo_ctrl_pkg::SIDE_ACTIVE: begin
        if (st_r.wr_hold != fifo_ctrl_pkg::STROBE_MIN_CYC) begin
          st_nxt.wr_hold = 2'(st_r.wr_hold + 1'b1);
        end
        // a short source pulse is stretched to the least width
        if (st_r.push_s2 &&
            (st_r.wr_hold == fifo_ctrl_pkg::STROBE_MIN_CYC)) begin
          st_nxt.push_st = fifo_ctrl_pkg::SIDE_IDLE;
          st_nxt.gpush_n = 1'b1;
          // new address appears only as the strobe rises
          st_nxt.wr_addr = st_r.wr_cnt;
        end
      end
      default: begin
        st_nxt.push_st = fifo_ctrl_pkg::SIDE_IDLE;
        st_nxt.gpush_n = 1'b1;
      end
    endcase
    // read side sequencer; staging room is checked up front because
    // the word is captured only at the end of the strobe
    case (st_r.pop_st)
      fifo_ctrl_pkg::SIDE_IDLE: begin
        if (!st_r.pop_s2 && !st_r.empty && st_r.rd_fresh &&
            stage_ready && !st_r.stage_valid) begin
          st_nxt.pop_st   = fifo_ctrl_pkg::SIDE_ACTIVE;
          st_nxt.gpop_n   = 1'b0;
          st_nxt.rd_cnt   = ADDR_W'(st_r.rd_cnt + 1'b1);
          st_nxt.rd_hold  = 2'h0;
          st_nxt.rd_fresh = 1'b0;
        end
      end
      fifo_ctrl_pkg::SIDE_ACTIVE: begin
        if (st_r.rd_hold != fifo_ctrl_pkg::STROBE_MIN_CYC) begin
          st_nxt.rd_hold = 2'(st_r.rd_hold + 1'b1);
        end
        if (st_r.pop_s2 &&
            (st_r.rd_hold == fifo_ctrl_pkg::STROBE_MIN_CYC)) begin
          st_nxt.pop_st      = fifo_ctrl_pkg::SIDE_IDLE;
          st_nxt.gpop_n      = 1'b1;
          st_nxt.rd_addr     = st_r.rd_cnt;
          // sampled data is two cycles old, still inside the strobe
          st_nxt.stage_valid = 1'b1;
          st_nxt.stage_data  = st_r.rdat_s2;
        end
      end
      default: begin
        st_nxt.pop_st = fifo_ctrl_pkg::SIDE_IDLE;
        st_nxt.gpop_n = 1'b1;
      end
    endcase
    // flags follow the fill count only while both sides rest
    if (quiet_w) begin
      st_nxt.full     = (fill_w >= FULL_LEVEL);
      st_nxt.afull    = (fill_w >= AFULL_LEVEL);
      st_nxt.aempty   = (fill_w <= AEMPTY_LEVEL);
      st_nxt.empty    = (fill_w == fifo_ctrl_pkg::EMPTY_LEVEL);
      st_nxt.wr_fresh = 1'b1;
      st_nxt.rd_fresh = 1'b1;
    end
    // master reset beats everything except the staging buffer
    if (mr_act_w) begin
      st_nxt.push_st  = fifo_ctrl_pkg::SIDE_IDLE;
      st_nxt.pop_st   = fifo_ctrl_pkg::SIDE_IDLE;
      st_nxt.gpush_n  = 1'b1;
      st_nxt.gpop_n   = 1'b1;
      st_nxt.wr_cnt   = fifo_ctrl_pkg::ADDR_RESET;
      st_nxt.rd_cnt   = fifo_ctrl_pkg::ADDR_RESET;
      st_nxt.wr_addr  = fifo_ctrl_pkg::ADDR_RESET;
      st_nxt.rd_addr  = fifo_ctrl_pkg::ADDR_RESET;
      st_nxt.empty    = 1'b1;
      st_nxt.aempty   = 1'b1;
      st_nxt.full     = 1'b0;
      st_nxt.afull    = 1'b0;
      st_nxt.wr_fresh = 1'b1;
      st_nxt.rd_fresh = 1'b1;
    end
  end

  // one register for the record; synchronous reset to an empty fifo
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      st_r          <= '0;
      st_r.push_st  <= fifo_ctrl_pkg::SIDE_IDLE;
      st_r.pop_st   <= fifo_ctrl_pkg::SIDE_IDLE;
      st_r.wr_cnt   <= fifo_ctrl_pkg::ADDR_RESET;
      st_r.rd_cnt   <= fifo_ctrl_pkg::ADDR_RESET;
      st_r.wr_addr  <= fifo_ctrl_pkg::ADDR_RESET;
      st_r.rd_addr  <= fifo_ctrl_pkg::ADDR_RESET;
      st_r.wdata    <= fifo_ctrl_pkg::DATA_RESET;
      st_r.empty    <= 1'b1;
      st_r.aempty   <= 1'b1;
      st_r.wr_fresh <= 1'b1;
      st_r.rd_fresh <= 1'b1;
      st_r.gpush_n  <= 1'b1;
      st_r.gpop_n   <= 1'b1;
      st_r.oel_n    <= 1'b1;
      st_r.rws      <= 1'b1;
      // idle pins read high, so no false strobe after release
      st_r.push_s1  <= 1'b1;
      st_r.push_s2  <= 1'b1;
      st_r.pop_s1   <= 1'b1;
      st_r.pop_s2   <= 1'b1;
      st_r.mr_s1    <= 1'b1;
      st_r.mr_s2    <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // read words wait here; a stalled drain holds off new pops
  stage_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (STAGE_DEPTH)
  ) u_stage (
    .clk       (sys_clk),
    .reset_n   (reset_n),
    .in_valid  (st_r.stage_valid),
    .in_ready  (stage_ready),
    .in_data   (st_r.stage_data),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_data)
  );

  // ram side outputs, each straight from the record
  assign write_address_bus          = st_r.wr_addr;
  assign read_address_bus           = st_r.rd_addr;
  assign write_data_bus             = st_r.wdata;
  assign gated_push_n               = st_r.gpush_n;
  assign gated_pop_n                = st_r.gpop_n;
  assign left_port_write_select     = st_r.gpush_n;
  assign left_port_chip_enable_n    = st_r.gpush_n;
  assign left_port_output_enable_n  = st_r.oel_n;
  assign right_port_output_enable_n = st_r.gpop_n;
  assign right_port_chip_enable_n   = st_r.gpop_n;
  assign right_port_write_select    = st_r.rws;
  assign full                       = st_r.full;
  assign almost_full                = st_r.afull;
  assign almost_empty               = st_r.aempty;
  assign empty                      = st_r.empty;

  // checks on the controller
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  property p_mr_counters;
    mr_act_w |=> (st_r.wr_cnt == '0) && (st_r.rd_cnt == '0);
  endproperty
  a_mr_counters: assert property (p_mr_counters)
    else $error("counters not zero after master reset");
  property p_mr_flags;
    mr_act_w |=> (write_address_bus == '0) && (read_address_bus == '0)
                 && empty && almost_empty && !full;
  endproperty
  a_mr_flags: assert property (p_mr_flags)
    else $error("latches or flags wrong after master reset");
  property p_push_gate;
    $fell(gated_push_n) |-> ($past(st_r.full) == 1'b0)
                            && ($past(st_r.push_s2) == 1'b0);
  endproperty
  a_push_gate: assert property (p_push_gate)
    else $error("push strobe passed while full or idle");
  property p_left_port;
    (left_port_chip_enable_n == gated_push_n)
      && (left_port_write_select == gated_push_n)
      && left_port_output_enable_n;
  endproperty
  a_left_port: assert property (p_left_port)
    else $error("left port controls wrong");
  property p_pop_gate;
    $fell(gated_pop_n) |-> ($past(st_r.empty) == 1'b0)
                           && ($past(st_r.pop_s2) == 1'b0);
  endproperty
  a_pop_gate: assert property (p_pop_gate)
    else $error("pop strobe passed while empty");
  property p_right_port;
    right_port_write_select && (right_port_chip_enable_n == gated_pop_n)
      && (right_port_output_enable_n == gated_pop_n);
  endproperty
  a_right_port: assert property (p_right_port)
    else $error("right port controls wrong");
  property p_empty_track;
    $past(quiet_w) && $past(st_r.mr_s2) |-> (empty == (fill_w == '0));
  endproperty
  a_empty_track: assert property (p_empty_track)
    else $error("empty flag disagrees with fill");
  property p_aempty_track;
    $past(quiet_w) && $past(st_r.mr_s2)
      |-> (almost_empty == (fill_w <= AEMPTY_LEVEL));
  endproperty
  a_aempty_track: assert property (p_aempty_track)
    else $error("almost empty flag disagrees with fill");
  property p_afull_track;
    $past(quiet_w) && $past(st_r.mr_s2)
      |-> (almost_full == (fill_w >= AFULL_LEVEL));
  endproperty
  a_afull_track: assert property (p_afull_track)
    else $error("almost full flag disagrees with fill");
  property p_full_track;
    $past(quiet_w) && $past(st_r.mr_s2)
      |-> (full == (fill_w >= FULL_LEVEL));
  endproperty
  a_full_track: assert property (p_full_track)
    else $error("full flag disagrees with fill");
  property p_flags_hold;
    !$past(quiet_w) && $past(st_r.mr_s2)
      |-> $stable({full, almost_full, almost_empty, empty});
  endproperty
  a_flags_hold: assert property (p_flags_hold)
    else $error("flag moved while a strobe was active");
  property p_wr_step;
    $fell(gated_push_n) |-> st_r.wr_cnt == ADDR_W'($past(st_r.wr_cnt) + 1);
  endproperty
  a_wr_step: assert property (p_wr_step)
    else $error("write counter did not step on push");
  property p_rd_step;
    $fell(gated_pop_n) |-> st_r.rd_cnt == ADDR_W'($past(st_r.rd_cnt) + 1);
  endproperty
  a_rd_step: assert property (p_rd_step)
    else $error("read counter did not step on pop");
  property p_wr_latch;
    (!gated_push_n && st_r.mr_s2) |=> $stable(write_address_bus)
                                      || $rose(gated_push_n);
  endproperty
  a_wr_latch: assert property (p_wr_latch)
    else $error("write address moved inside strobe");
  property p_rd_present;
    $rose(gated_pop_n) && st_r.mr_s2 |-> read_address_bus == st_r.rd_cnt;
  endproperty
  a_rd_present: assert property (p_rd_present)
    else $error("read address not updated on rising strobe");
  property p_fill_range;
    fill_w <= FULL_LEVEL;
  endproperty
  a_fill_range: assert property (p_fill_range)
    else $error("fill count out of range");
  c_full:    cover property ($rose(full));
  c_refused: cover property (!st_r.push_s2 && full && quiet_w == 1'b0);
  c_drained: cover property ($rose(empty) && st_r.mr_s2);
  c_stall:   cover property (!stage_ready && !st_r.pop_s2);

endmodule : ram_fifo_ctrl
`default_nettype wire

//--- sim/dual_port_ram_model.sv
`timescale 1ns/1ns
`default_nettype none
module dual_port_ram_model (
  input  wire logic       sys_clk,
  input  wire logic [3:0] write_address_bus,
  input  wire logic [3:0] read_address_bus,
  input  wire logic [7:0] write_data_bus,
  input  wire logic       left_port_write_select,
  input  wire logic       left_port_chip_enable_n,
  input  wire logic       right_port_output_enable_n,
  input  wire logic       right_port_chip_enable_n,
  input  wire logic       right_port_write_select,
  output logic      [7:0] read_data_bus
);
  logic [7:0] cells [16];     // storage, one word per address
  logic [7:0] junk_r = 8'h3C; // moves every cycle, a floating bus
  logic       rd_on;          // right port driving its data lines

  // left port stores while enabled and set to write
  always_ff @(posedge sys_clk) begin
    junk_r <= junk_r + 8'h5B;
    if (!left_port_chip_enable_n && !left_port_write_select) begin
      cells[write_address_bus] <= write_data_bus;
    end
  end

  // right port: drives only when enabled and in read mode, else junk
  // so a controller sampling outside the strobe sees no stale word
  assign rd_on = !right_port_chip_enable_n && !right_port_output_enable_n
                 && right_port_write_select;
  assign read_data_bus = rd_on ? cells[read_address_bus] : junk_r;
endmodule : dual_port_ram_model
`default_nettype wire

//--- sim/dual_port_ram_fifo_controller_bench.sv
`timescale 1ns/1ns
`default_nettype none
module dual_port_ram_fifo_controller_bench;
  logic       sys_clk, reset_n, master_reset_n, push_n, pop_n, out_ready;
  logic [7:0] push_data, write_data_bus, read_data_bus, out_data;
  logic [3:0] write_address_bus, read_address_bus;
  logic       gated_push_n, gated_pop_n, out_valid;
  logic       left_port_write_select, left_port_chip_enable_n;
  logic       left_port_output_enable_n, right_port_output_enable_n;
  logic       right_port_chip_enable_n, right_port_write_select;
  logic       full, almost_full, almost_empty, empty;
  logic [7:0] exp_q [$];       // words expected at the drain, in order
  logic [3:0] wc, rc;          // expected write and read counters
  logic [3:0] wa_prev, ra_prev, fl_prev;
  logic       gp_prev, gq_prev;
  int         bad_count, total_checks, cycles;

  ram_fifo_ctrl dut (.sys_clk, .reset_n, .master_reset_n, .push_n,
    .pop_n, .push_data, .write_address_bus, .read_address_bus,
    .write_data_bus, .read_data_bus, .gated_push_n, .gated_pop_n,
    .left_port_write_select, .left_port_chip_enable_n,
    .left_port_output_enable_n, .right_port_output_enable_n,
    .right_port_chip_enable_n, .right_port_write_select, .full,
    .almost_full, .almost_empty, .empty, .out_valid, .out_ready,
    .out_data);

  dual_port_ram_model ram (.sys_clk, .write_address_bus,
    .read_address_bus, .write_data_bus, .left_port_write_select,
    .left_port_chip_enable_n, .right_port_output_enable_n,
    .right_port_chip_enable_n, .right_port_write_select,
    .read_data_bus);

  // 20 MHz clock
  initial sys_clk = 1'h0;
  always #25 sys_clk = ~sys_clk;

  task automatic chk(input string what, input logic [7:0] exp,
                     input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  // flags from the expected fill, addresses from the expected counters, read while idle
  task automatic flags_chk;
    logic [3:0] n;
    n = wc - rc;
    chk("flags", {4'h0, n >= 4'h8, n >= 4'h6, n <= 4'h2, n == 4'h0},
        {4'h0, full, almost_full, almost_empty, empty});
    chk("write addr", {4'h0, wc}, {4'h0, write_address_bus});
    chk("read addr", {4'h0, rc}, {4'h0, read_address_bus});
  endtask : flags_chk

  // one strobe held eight cycles, then eight quiet cycles
  task automatic op(input logic pop, input logic [7:0] d);
    logic       acc, seen;
    logic [3:0] n;
    n = wc - rc;
    acc = pop ? (n != 4'h0) : (n < 4'h8);
    seen = 1'h0;
    @(negedge sys_clk);
    if (pop) pop_n = 1'h0;
    else begin
      push_n = 1'h0;
      push_data = d;
    end
    repeat (8) begin
      @(negedge sys_clk);
      if ((pop ? gated_pop_n : gated_push_n) === 1'h0) seen = 1'h1;
    end
    push_n = 1'h1;
    pop_n = 1'h1;
    repeat (8) @(negedge sys_clk);
    chk("strobe taken", {7'h0, acc}, {7'h0, seen});
    if (acc && pop) rc = rc + 4'h1;
    if (acc && !pop) begin
      wc = wc + 4'h1;
      exp_q.push_back(d);
    end
    flags_chk();
  endtask : op

  // port wiring, address hold and flag hold while a strobe is low
  always @(negedge sys_clk) begin
    if (reset_n) begin
      chk("left port", {6'h01, gated_push_n, gated_push_n},
          {5'h0, left_port_output_enable_n, left_port_write_select,
           left_port_chip_enable_n});
      chk("right port", {6'h01, gated_pop_n, gated_pop_n},
          {5'h0, right_port_write_select, right_port_output_enable_n,
           right_port_chip_enable_n});
      if (!gp_prev && !gated_push_n)
        chk("write addr hold", {4'h0, wa_prev}, {4'h0, write_address_bus});
      if (!gq_prev && !gated_pop_n)
        chk("read addr hold", {4'h0, ra_prev}, {4'h0, read_address_bus});
      if ((!gp_prev && !gated_push_n) || (!gq_prev && !gated_pop_n))
        chk("flag hold", {4'h0, fl_prev},
            {4'h0, full, almost_full, almost_empty, empty});
    end
    gp_prev = gated_push_n;
    gq_prev = gated_pop_n;
    wa_prev = write_address_bus;
    ra_prev = read_address_bus;
    fl_prev = {full, almost_full, almost_empty, empty};
  end

  // drain side: every word leaving must be the oldest one written
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 6000) begin
      bad_count++;
      end_of_test();
    end else if (reset_n && out_valid === 1'h1 && out_ready === 1'h1) begin
      chk("out data", exp_q.size() ? exp_q.pop_front() : ~out_data,
          out_data);
    end
  end

  initial begin
    reset_n = 1'h0;
    master_reset_n = 1'h1;
    push_n = 1'h1;
    pop_n = 1'h1;
    out_ready = 1'h1;
    push_data = 8'h00;
    wc = 4'h0;
    rc = 4'h0;
    repeat (16) @(negedge sys_clk);
    reset_n = 1'h1;
    @(negedge sys_clk);
    flags_chk();
    op(1'h1, 8'h00);
    $display("test reset and empty pop finished");
    for (int i = 0; i < 9; i++) op(1'h0, 8'(i * 37 + 5));
    op(1'h1, 8'h00);
    op(1'h0, 8'hE7);
    $display("test fill to full finished");
    // drain stalls so popped words pile up in the staging buffer
    out_ready = 1'h0;
    for (int i = 0; i < 9; i++) op(1'h1, 8'h00);
    out_ready = 1'h1;
    repeat (24) @(negedge sys_clk);
    chk("left over", 8'h00, 8'(exp_q.size()));
    $display("test drain finished");
    for (int i = 0; i < 12; i++) begin
      op(1'h0, 8'(8'hA0 + i));
      op(1'h1, 8'h00);
    end
    $display("test wrap finished");
    for (int i = 0; i < 3; i++) op(1'h0, 8'(i + 1));
    master_reset_n = 1'h0;
    repeat (4) @(negedge sys_clk);
    master_reset_n = 1'h1;
    repeat (6) @(negedge sys_clk);
    wc = 4'h0;
    rc = 4'h0;
    exp_q.delete();
    flags_chk();
    op(1'h0, 8'h5A);
    op(1'h1, 8'h00);
    repeat (8) @(negedge sys_clk);
    $display("test master reset finished");
    end_of_test();
  end
endmodule : dual_port_ram_fifo_controller_bench
`default_nettype wire
